// ---- testbench/tx_length_registers_tb.sv ----
`timescale 1ns/1ps
module tx_length_registers_tb;
  reg         clk = 0, r = 1, en = 1, f = 0;
  wire        w, bb;
  wire [4:0]  a;
  wire [7:0]  d, q;
  wire [11:0] n;
  wire [2:0]  nb;
  int failures = 0, checks_done = 0, c = 0;
  always #50 clk = ~clk;
  // the sequence below needs about 42 cycles
  always @(posedge clk) if (++c > 200) begin
    failures++;
    $display("ERROR %0t timeout", $time);
    print_verdict;
  end
  txlen_host i_host (.clk(clk), .w(w), .a(a), .d(d));
  txlen_registers i_dut (.clk(clk), .sys_rst(r), .chip_en(en), .tx_eof(f), .reg_addr(a),
    .reg_wr(w), .reg_wdata(d), .reg_rdata(q), .byte_count(n), .broken_byte(bb),
    .broken_bits(nb));
  task check_count(input [11:0] g, input [11:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("ERROR %0t count %h expected %h", $time, g, e);
    end
  endtask
  task check_read(input [7:0] g, input [7:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("ERROR %0t read %h expected %h", $time, g, e);
    end
  endtask
  task check_broken(input [3:0] g, input [3:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("ERROR %0t broken %h expected %h", $time, g, e);
    end
  endtask
  task print_verdict;
    $display("failures %0d checks %0d", failures, checks_done);
    if (failures == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    r <= 0;
    repeat (3) @(posedge clk);
    i_host.put(5'h1D, 8'hA5, 1);
    i_host.put(5'h1E, 8'h3C, 1);
    check_count(n, 12'hA53);
    check_broken({bb, nb}, 4'hC);
    i_host.put(5'h1D, 8'h00, 0);
    check_read(q, 8'hA5);
    i_host.put(5'h1E, 8'h00, 0);
    check_read(q, 8'h3C);
    i_host.put(5'h1C, 8'h00, 0);
    check_read(q, 8'h00);
    i_host.put(5'h1E, 8'h80, 1);
    check_count(n, 12'hA58);
    @(posedge clk) f <= 1;
    @(posedge clk) f <= 0;
    #1 check_count(n, 12'h000);
    check_broken({bb, nb}, 4'h0);
    i_host.put(5'h1D, 8'h12, 1);
    i_host.put(5'h1E, 8'h30, 1);
    check_count(n, 12'h123);
    fork
      i_host.put(5'h1D, 8'h55, 1);
      begin
        @(posedge clk) f <= 1;
        @(posedge clk) f <= 0;
      end
    join
    check_count(n, 12'h000);
    i_host.put(5'h1D, 8'h66, 1);
    check_count(n, 12'h660);
    @(posedge clk) r <= 1;
    @(posedge clk) r <= 0;
    #1 check_count(n, 12'h000);
    i_host.put(5'h1D, 8'h77, 1);
    check_count(n, 12'h000);
    i_host.put(5'h1D, 8'h77, 1);
    check_count(n, 12'h770);
    @(posedge clk) en <= 0;
    repeat (3) @(posedge clk);
    #1 check_count(n, 12'h000);
    i_host.put(5'h1D, 8'hFF, 1);
    check_count(n, 12'h000);
    print_verdict;
  end
endmodule // tx_length_registers_tb

// ---- testbench/txlen_chk.sv ----
`timescale 1ns/1ps
module txlen_chk (input wire clk, input wire sys_rst, input wire chip_en, input wire tx_eof,
  input wire [4:0] reg_addr, input wire reg_wr, input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata, input wire [11:0] byte_count, input wire broken_byte,
  input wire [2:0] broken_bits);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // enable passes two sync flops, so three samples at one level settle it
  sequence en_held; chip_en[*3]; endsequence
  sequence hi_wr; en_held ##0 (reg_wr && !tx_eof && reg_addr == 5'h1D); endsequence
  sequence lo_wr; en_held ##0 (reg_wr && !tx_eof && reg_addr == 5'h1E); endsequence
  sequence quiet; en_held ##0 (!reg_wr && !tx_eof); endsequence
  AST_EOF: assert property (tx_eof |=> byte_count == 12'h000)
    else $error("count not cleared at eof");
  AST_EN: assert property ((!chip_en)[*3] |=> byte_count == 12'h000)
    else $error("count not cleared with enable low");
  AST_HI: assert property (hi_wr |=> byte_count[11:4] == $past(reg_wdata))
    else $error("high write not taken");
  AST_LO: assert property (lo_wr |=> byte_count[3:0] == $past(reg_wdata[7:4]))
    else $error("low write not taken");
  AST_BRK: assert property (lo_wr |=> {broken_byte, broken_bits} == $past(reg_wdata[3:0]))
    else $error("broken byte fields wrong");
  AST_HOLD: assert property (quiet |=> $stable(byte_count))
    else $error("count changed without cause");
  AST_RD_HI: assert property (reg_addr == 5'h1D |=> reg_rdata == $past(byte_count[11:4]))
    else $error("high read data wrong");
  AST_RD_LO: assert property (reg_addr == 5'h1E |=>
    reg_rdata == $past({byte_count[3:0], broken_byte, broken_bits}))
    else $error("low read data wrong");
  AST_RD_NONE: assert property (reg_addr != 5'h1D && reg_addr != 5'h1E |=>
    reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_RST: assert property ($fell(sys_rst) |-> byte_count == 12'h000 && reg_rdata == 8'h00)
    else $error("not zero after reset");
endmodule // txlen_chk
bind txlen_registers txlen_chk i_chk (.*);

// ---- testbench/txlen_host.sv ----
`timescale 1ns/1ps
module txlen_host (input wire clk, output reg w = 0, output reg [4:0] a = 0,
  output reg [7:0] d = 0);
  // e low makes a plain read; data goes inverted once released
  task put(input [4:0] x, input [7:0] y, input e);
    @(posedge clk) begin w <= e; a <= x; d <= y; end
    @(posedge clk) begin w <= 0; d <= ~y; end
    #1;
  endtask
endmodule // txlen_host

// ---- verilog/txlen_defs.vh ----
`ifndef TXLEN_DEFS_VH
`define TXLEN_DEFS_VH
`define TXLEN_ADDR_HIGH    5'h1D
`define TXLEN_ADDR_LOW     5'h1E
`define TXLEN_RESET_VALUE  8'h00
`define TXLEN_HI_NIB_MSB   7
`define TXLEN_HI_NIB_LSB   4
`define TXLEN_LO_NIB_MSB   3
`define TXLEN_LO_NIB_LSB   0
`define TXLEN_CNT_LO_MSB   7
`define TXLEN_CNT_LO_LSB   4
`define TXLEN_BROKEN_BIT   3
`define TXLEN_BITS_MSB     2
`define TXLEN_BITS_LSB     0
`endif

// ---- verilog/txlen_registers.v ----
`timescale 1ns/1ps
`include "txlen_defs.vh"
module txlen_registers (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        chip_en,
  input  wire        tx_eof,
  input  wire [4:0]  reg_addr,
  input  wire        reg_wr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  output wire [11:0] byte_count,
  output wire        broken_byte,
  output wire [2:0]  broken_bits
);

  wire        en_sync;
  wire        clear_on_disable;
  wire        clear_on_eof;
  wire        clear_all;
  wire        sel_high;
  wire        sel_low;
  wire        wr_high;
  wire        wr_low;
  wire [7:0]  tx_byte_count_high;
  wire [7:0]  tx_byte_count_low_partial;
  wire [3:0]  low_count_field;
  wire        broken_flag_field;
  wire [2:0]  broken_count_field;
  wire        count_bit_eleven;
  wire        count_bit_ten;
  wire        count_bit_nine;
  wire        count_bit_eight;
  wire        count_bit_seven;
  wire        count_bit_six;
  wire        count_bit_five;
  wire        count_bit_four;
  wire        count_bit_three;
  wire        count_bit_two;
  wire        count_bit_one;
  wire        count_bit_zero;
  reg  [7:0]  next_reg_rdata;

  // enable is a pin; two stages before any logic reads it
  txlen_sync2 i_en_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in (chip_en),
    .sync_out (en_sync)
  );

  // enable low clears two clocks late; a write just after the pin falls still lands
  assign clear_on_disable = !en_sync;
  // eof beats a same-cycle host write: the frame is over, the count is stale
  assign clear_on_eof     = tx_eof;
  assign clear_all        = clear_on_disable || clear_on_eof;

  txlen_sel #(
    .ADDR (`TXLEN_ADDR_HIGH)
  ) i_sel_high (
    .reg_addr (reg_addr),
    .reg_wr   (reg_wr),
    .hit      (sel_high),
    .wr_hit   (wr_high)
  );

  txlen_sel #(
    .ADDR (`TXLEN_ADDR_LOW)
  ) i_sel_low (
    .reg_addr (reg_addr),
    .reg_wr   (reg_wr),
    .hit      (sel_low),
    .wr_hit   (wr_low)
  );

  txlen_reg8 #(
    .RESET_VALUE (`TXLEN_RESET_VALUE)
  ) i_count_high (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clr     (clear_all),
    .wr      (wr_high),
    .wdata   (reg_wdata),
    .q       (tx_byte_count_high)
  );

  txlen_reg8 #(
    .RESET_VALUE (`TXLEN_RESET_VALUE)
  ) i_count_low (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clr     (clear_all),
    .wr      (wr_low),
    .wdata   (reg_wdata),
    .q       (tx_byte_count_low_partial)
  );

  // high register: count bits 11 down to 4
  assign count_bit_eleven = tx_byte_count_high[`TXLEN_HI_NIB_MSB];
  assign count_bit_ten    = tx_byte_count_high[6];
  assign count_bit_nine   = tx_byte_count_high[5];
  assign count_bit_eight  = tx_byte_count_high[`TXLEN_HI_NIB_LSB];
  assign count_bit_seven  = tx_byte_count_high[`TXLEN_LO_NIB_MSB];
  assign count_bit_six    = tx_byte_count_high[2];
  assign count_bit_five   = tx_byte_count_high[1];
  assign count_bit_four   = tx_byte_count_high[`TXLEN_LO_NIB_LSB];

  // low register fields; the broken-byte layout is assumed: flag then bit count
  assign low_count_field    = tx_byte_count_low_partial[`TXLEN_CNT_LO_MSB:`TXLEN_CNT_LO_LSB];
  assign broken_flag_field  = tx_byte_count_low_partial[`TXLEN_BROKEN_BIT];
  assign broken_count_field = tx_byte_count_low_partial[`TXLEN_BITS_MSB:`TXLEN_BITS_LSB];

  assign count_bit_three = low_count_field[3];
  assign count_bit_two   = low_count_field[2];
  assign count_bit_one   = low_count_field[1];
  assign count_bit_zero  = low_count_field[0];

  assign byte_count[11] = count_bit_eleven;
  assign byte_count[10] = count_bit_ten;
  assign byte_count[9]  = count_bit_nine;
  assign byte_count[8]  = count_bit_eight;
  assign byte_count[7]  = count_bit_seven;
  assign byte_count[6]  = count_bit_six;
  assign byte_count[5]  = count_bit_five;
  assign byte_count[4]  = count_bit_four;
  assign byte_count[3]  = count_bit_three;
  assign byte_count[2]  = count_bit_two;
  assign byte_count[1]  = count_bit_one;
  assign byte_count[0]  = count_bit_zero;

  assign broken_byte = broken_flag_field;
  assign broken_bits = broken_count_field;

  // unmapped addresses read zero, so a stray read never aliases a register
  always @* begin
    next_reg_rdata = 8'h00;
    case ({sel_high, sel_low})
      2'h2: begin
        next_reg_rdata = tx_byte_count_high;
      end
      2'h1: begin
        next_reg_rdata = tx_byte_count_low_partial;
      end
      default: begin
        next_reg_rdata = 8'h00;
      end
    endcase
  end

  // read data is registered: it lags the address by one clock
  always @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end
endmodule // txlen_registers

// address match for one register; the write strobe is gated by the match
module txlen_sel #(
  parameter [4:0] ADDR = 5'h00
) (
  input  wire [4:0] reg_addr,
  input  wire       reg_wr,
  output wire       hit,
  output wire       wr_hit
);
  assign hit    = (reg_addr == ADDR);
  assign wr_hit = reg_wr && hit;
endmodule // txlen_sel

// one length register; a clear always outranks a write in the same cycle
module txlen_reg8 #(
  parameter [7:0] RESET_VALUE = `TXLEN_RESET_VALUE
) (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire       clr,
  input  wire       wr,
  input  wire [7:0] wdata,
  output reg  [7:0] q
);
  reg  [7:0] next_q;

  always @* begin
    next_q = q;
    case ({clr, wr})
      2'h0: begin
        next_q = q;
      end
      2'h1: begin
        next_q = wdata;
      end
      2'h2: begin
        next_q = RESET_VALUE;
      end
      2'h3: begin
        next_q = RESET_VALUE;
      end
      default: begin
        next_q = q;
      end
    endcase
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      q <= RESET_VALUE;
    end else begin
      q <= next_q;
    end
  end
endmodule // txlen_reg8

// plain two-flop synchroniser; only the second stage leaves the module
module txlen_sync2 (
  input  wire clk,
  input  wire sys_rst,
  input  wire async_in,
  output reg  sync_out
);
  reg  stage_meta;

  always @(posedge clk) begin
    if (sys_rst) begin
      stage_meta <= 1'h0;
      sync_out   <= 1'h0;
    end else begin
      stage_meta <= async_in;
      sync_out   <= stage_meta;
    end
  end
endmodule // txlen_sync2
